// ==== design/cit_defs.vh ====
/*
  Constants of the instruction timing and flag block: machine cycle
  phases, instruction lengths, cycle counts, flag bit positions.
  Assumes inclusion by bare name from design files; definitions only.
*/
// Behaviour
// - Machine cycle is exactly four clocks
// - At most one code byte fetched per cycle
// - Cycles equal byte count for most instructions
// - Jumps and calls take one extra cycle
// - Flag results match the reference instruction set
// - Add/subtract set carry, overflow, half carry; multiply/divide carry, overflow; others carry
// - Multiply/divide clear carry; clear/set carry force it
// - Absolute call: two bytes, three cycles
// - Absolute jump: two bytes, three cycles
// - Overflow is carry six xor carry seven
// - Parity flag tracks accumulator ones count
`ifndef CIT_DEFS_VH
`define CIT_DEFS_VH
`define CIT_CLK_PER_MC 3'h4
`define CIT_PHASE_LAST 2'h3
`define CIT_PHASE_FETCH 2'h0
`define CIT_LEN_W 2
`define CIT_MC_W 3
`define CIT_RESET_ACC 8'h00
`define CIT_RESET_PC 16'h0000
`define CIT_FLAG_CY 7
`define CIT_FLAG_AC 6
`define CIT_FLAG_OV 2
`define CIT_FLAG_P 0
`define CIT_RESET_PSW 8'h00
`endif

// ==== design/cit_flag_alu.v ====
/*
  Flag unit: computes carry, half carry, overflow and result of the
  flag-changing operations. Purely combinational; the sequencer
  decides when the results are written back.
*/
`timescale 1ns/1ps
module cit_flag_alu (
  input wire [3:0] op_class,
  input wire [7:0] acc,
  input wire [7:0] operand,
  input wire [7:0] b_reg,
  input wire carry_in,
  input wire bit_in,
  output reg [7:0] result,
  output reg carry_flag,
  output reg half_carry_flag,
  output reg signed_overflow_flag,
  output reg wr_acc,
  output reg wr_cy,
  output reg wr_ac,
  output reg wr_ov
);
  localparam C_NONE = 4'h0, C_ADD = 4'h1, C_ADD_WITH_CARRY_OP = 4'h2, C_SUBTRACT_WITH_BORROW_OP = 4'h3;
  localparam C_MUL = 4'h4, C_DIV = 4'h5, C_DA = 4'h6, C_RRC = 4'h7;
  localparam C_RLC = 4'h8, C_CLRC = 4'h9, C_SETC = 4'hA, C_CPLC = 4'hB;
  localparam C_ANLC = 4'hC, C_ORLC = 4'hD, C_MOVC = 4'hE, C_COMPARE_JUMP_UNEQUAL_OP = 4'hF;
  reg [4:0] lo;
  reg [3:0] mid;
  reg [1:0] hi;
  reg [7:0] rhs;
  reg cin;
  reg [15:0] prod;
  reg [8:0] da_t;
  // Add/subtract split at bits 3 and 6 to expose the inner carries
  always @* begin
    result = acc;
    carry_flag = carry_in;
    half_carry_flag = 1'b0;
    signed_overflow_flag = 1'b0;
    wr_acc = 1'b0;
    wr_cy = 1'b0;
    wr_ac = 1'b0;
    wr_ov = 1'b0;
    rhs = (op_class == C_SUBTRACT_WITH_BORROW_OP) ? ~operand : operand;
    cin = (op_class == C_SUBTRACT_WITH_BORROW_OP) ? ~carry_in : ((op_class == C_ADD_WITH_CARRY_OP) & carry_in);
    lo = {1'b0, acc[3:0]} + {1'b0, rhs[3:0]} + {4'h0, cin};
    mid = {1'b0, acc[6:4]} + {1'b0, rhs[6:4]} + {3'h0, lo[4]};
    hi = {1'b0, acc[7]} + {1'b0, rhs[7]} + {1'b0, mid[3]};
    prod = acc * b_reg;
    da_t = {1'b0, acc};
    case (op_class)
      C_ADD, C_ADD_WITH_CARRY_OP, C_SUBTRACT_WITH_BORROW_OP: begin
        result = {hi[0], mid[2:0], lo[3:0]};
        // Subtract reports borrows, the inverse of adder carries
        carry_flag = hi[1] ^ (op_class == C_SUBTRACT_WITH_BORROW_OP);
        half_carry_flag = lo[4] ^ (op_class == C_SUBTRACT_WITH_BORROW_OP);
        signed_overflow_flag = mid[3] ^ hi[1];
        wr_acc = 1'b1;
        wr_cy = 1'b1;
        wr_ac = 1'b1;
        wr_ov = 1'b1;
      end
      C_MUL: begin
        result = prod[7:0];
        carry_flag = 1'b0;
        signed_overflow_flag = |prod[15:8];
        wr_acc = 1'b1;
        wr_cy = 1'b1;
        wr_ov = 1'b1;
      end
      C_DIV: begin
        // Quotient alone returned; divide by zero flags overflow
        result = (b_reg == 8'h00) ? acc : acc / b_reg;
        carry_flag = 1'b0;
        signed_overflow_flag = (b_reg == 8'h00);
        wr_acc = 1'b1;
        wr_cy = 1'b1;
        wr_ov = 1'b1;
      end
      C_DA: begin
        if (acc[3:0] > 4'h9 || carry_in)
          da_t = {1'b0, acc} + 9'h006;
        if (da_t[7:4] > 4'h9 || da_t[8] || carry_in)
          da_t = da_t + 9'h060;
        result = da_t[7:0];
        carry_flag = da_t[8] | carry_in;
        wr_acc = 1'b1;
        wr_cy = 1'b1;
      end
      C_RRC: begin
        result = {carry_in, acc[7:1]};
        carry_flag = acc[0];
        wr_acc = 1'b1;
        wr_cy = 1'b1;
      end
      C_RLC: begin
        result = {acc[6:0], carry_in};
        carry_flag = acc[7];
        wr_acc = 1'b1;
        wr_cy = 1'b1;
      end
      C_CLRC: begin
        carry_flag = 1'b0;
        wr_cy = 1'b1;
      end
      C_SETC: begin
        carry_flag = 1'b1;
        wr_cy = 1'b1;
      end
      C_CPLC: begin
        carry_flag = ~carry_in;
        wr_cy = 1'b1;
      end
      C_ANLC: begin
        carry_flag = carry_in & bit_in;
        wr_cy = 1'b1;
      end
      C_ORLC: begin
        carry_flag = carry_in | bit_in;
        wr_cy = 1'b1;
      end
      C_MOVC: begin
        carry_flag = bit_in;
        wr_cy = 1'b1;
      end
      C_COMPARE_JUMP_UNEQUAL_OP: begin
        carry_flag = acc < operand;
        wr_cy = 1'b1;
      end
      default: begin
        result = acc;
      end
    endcase
  end
endmodule

// ==== design/cit_sequencer.v ====
/*
  Instruction sequencer: builds four-clock machine cycles, fetches at most one
  code byte per cycle, decodes length and cycle count, and writes the
  flag unit's results into the status word.
  Assumes program memory answers a fetch address with its byte by the
  last phase of the same machine cycle (same clock domain).
*/
`timescale 1ns/1ps
`include "cit_defs.vh"
module cit_sequencer (
  input wire clk,
  input wire reset,
  input wire [7:0] code_data,
  input wire [7:0] b_reg,
  input wire bit_in,
  output reg [15:0] code_addr,
  output wire code_fetch,
  output reg [1:0] mc_phase,
  output reg instr_done,
  output reg [7:0] opcode,
  output reg [7:0] acc,
  output reg [7:0] psw,
  output reg [2:0] mc_count
);
  localparam S_OPC = 2'h0, S_OPND = 2'h1, S_EXTRA = 2'h2;
  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [1:0] bytes_left_q;
  reg [2:0] mc_left_q;
  reg [7:0] operand_q;
  reg [3:0] cls;
  reg [1:0] len;
  reg [2:0] mcs;
  wire [7:0] alu_res;
  wire alu_cy, alu_ac, alu_ov, w_acc, w_cy, w_ac, w_ov;
  wire mc_end;
  wire [7:0] cur_op;
  wire [7:0] cur_opnd;

  // Length in bytes; unlisted opcodes default to one byte
  function [1:0] op_len;
    input [7:0] op;
    begin
      if (op[4:0] == 5'h01 || op[4:0] == 5'h11)
        op_len = 2'h2;
      else if (op == 8'h24 || op == 8'h25 || op == 8'h34 || op == 8'h35)
        op_len = 2'h2;
      else if (op == 8'h82 || op == 8'hB0 || op == 8'h72 || op == 8'hA0 || op == 8'hA2)
        op_len = 2'h2;
      else if (op[7:4] == 4'hB && op[3:0] >= 4'h4)
        op_len = 2'h3;
      else
        op_len = 2'h1;
    end
  endfunction

  // Jumps and calls cost one cycle more than their length
  function is_branch;
    input [7:0] op;
    begin
      is_branch = (op[4:0] == 5'h01) || (op[4:0] == 5'h11) ||
                  (op[7:4] == 4'hB && op[3:0] >= 4'h4);
    end
  endfunction

  // Flag class of each opcode for the flag unit
  function [3:0] op_class;
    input [7:0] op;
    begin
      case (op[7:4])
        4'h2: op_class = (op[3:0] >= 4'h4) ? 4'h1 : 4'h0;
        4'h3: op_class = (op[3:0] >= 4'h4) ? 4'h2 : ((op[3:0] == 4'h3) ? 4'h8 : 4'h0);
        4'h9: op_class = (op[3:0] >= 4'h4) ? 4'h3 : 4'h0;
        4'hA: op_class = (op == 8'hA4) ? 4'h4 : ((op == 8'hA0 || op == 8'hA2) ? {3'h6, op[1]} : 4'h0);
        4'h8: op_class = (op == 8'h84) ? 4'h5 : ((op == 8'h82) ? 4'hC : 4'h0);
        4'hD: op_class = (op == 8'hD4) ? 4'h6 : ((op == 8'hD3) ? 4'hA : 4'h0);
        4'h1: op_class = (op == 8'h13) ? 4'h7 : 4'h0;
        4'hC: op_class = (op == 8'hC3) ? 4'h9 : 4'h0;
        4'hB: op_class = (op == 8'hB3) ? 4'hB : ((op == 8'hB0) ? 4'hC : ((op[3:0] >= 4'h4) ? 4'hF : 4'h0));
        4'h7: op_class = (op == 8'h72) ? 4'hD : 4'h0;
        default: op_class = 4'h0;
      endcase
    end
  endfunction

  assign mc_end = (mc_phase == `CIT_PHASE_LAST);
  // Single fetch strobe per machine cycle, only while bytes remain
  assign code_fetch = (mc_phase == `CIT_PHASE_FETCH) && (state_q != S_EXTRA);
  assign cur_op = (state_q == S_OPC) ? code_data : opcode;
  assign cur_opnd = (state_q == S_OPC) ? operand_q : code_data;

  // Decode of the instruction currently being completed
  always @* begin
    cls = op_class(cur_op);
    len = op_len(cur_op);
    mcs = {1'b0, len} + {2'h0, is_branch(cur_op)};
    state_d = state_q;
    if (mc_end) begin
      case (state_q)
        S_OPC: state_d = (len > 2'h1) ? S_OPND : S_OPC;
        S_OPND: state_d = (bytes_left_q > 2'h1) ? S_OPND : ((mc_left_q > 3'h1) ? S_EXTRA : S_OPC);
        S_EXTRA: state_d = S_OPC;
        default: state_d = S_OPC;
      endcase
    end
  end

  cit_flag_alu u_alu (
    .op_class(cls),
    .acc(acc),
    .operand(cur_opnd),
    .b_reg(b_reg),
    .carry_in(psw[`CIT_FLAG_CY]),
    .bit_in(bit_in),
    .result(alu_res),
    .carry_flag(alu_cy),
    .half_carry_flag(alu_ac),
    .signed_overflow_flag(alu_ov),
    .wr_acc(w_acc),
    .wr_cy(w_cy),
    .wr_ac(w_ac),
    .wr_ov(w_ov)
  );

  // Four-phase machine cycle and instruction bookkeeping
  always @(posedge clk) begin
    if (reset) begin
      mc_phase <= 2'h0;
      state_q <= S_OPC;
      bytes_left_q <= 2'h0;
      mc_left_q <= 3'h0;
      operand_q <= 8'h00;
      opcode <= 8'h00;
      code_addr <= `CIT_RESET_PC;
      acc <= `CIT_RESET_ACC;
      psw <= `CIT_RESET_PSW;
      instr_done <= 1'b0;
      mc_count <= 3'h0;
    end else begin
      mc_phase <= mc_phase + 2'h1;
      instr_done <= 1'b0;
      if (mc_end) begin
        state_q <= state_d;
        // Next byte address moves once per fetching cycle
        if (state_q != S_EXTRA)
          code_addr <= code_addr + 16'h0001;
        if (state_q == S_OPC) begin
          opcode <= code_data;
          bytes_left_q <= len - 2'h1;
          mc_left_q <= mcs - 3'h1;
          mc_count <= 3'h1;
        end else begin
          if (state_q == S_OPND) begin
            operand_q <= code_data;
            bytes_left_q <= bytes_left_q - 2'h1;
          end
          mc_left_q <= mc_left_q - 3'h1;
          mc_count <= mc_count + 3'h1;
        end
        // Retire on last machine cycle; carry, half carry and overflow written only then
        if (state_d == S_OPC) begin
          instr_done <= 1'b1;
          if (w_acc)
            acc <= alu_res;
          if (w_cy)
            psw[`CIT_FLAG_CY] <= alu_cy;
          if (w_ac)
            psw[`CIT_FLAG_AC] <= alu_ac;
          if (w_ov)
            psw[`CIT_FLAG_OV] <= alu_ov;
        end
      end
      // Parity follows the value the accumulator holds now
      psw[`CIT_FLAG_P] <= ^acc;
    end
  end
endmodule

// ==== testbench/cit_prog_mem.sv ====
/*
  Program memory model: a ROM that keeps driving its byte.
  Assumes the bench fills every location before reset ends.
*/
`timescale 1ns/1ps
module cit_prog_mem (
  input wire logic [15:0] code_addr,
  output logic [7:0] code_data
);
  logic [7:0] mem [0:255];
  // Only the low address byte decodes; programs stay short
  assign code_data = mem[code_addr[7:0]];
endmodule

// ==== testbench/cit_seq_props.sv ====
/*
  Port checker for the instruction sequencer.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
module cit_seq_props (
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] code_data,
  input wire logic [7:0] b_reg,
  input wire logic bit_in,
  input wire logic [15:0] code_addr,
  input wire logic code_fetch,
  input wire logic [1:0] mc_phase,
  input wire logic instr_done,
  input wire logic [7:0] opcode,
  input wire logic [7:0] acc,
  input wire logic [7:0] psw,
  input wire logic [2:0] mc_count
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // Four phases, then back to the fetch phase
  sequence s_mc;
    mc_phase == 2'h1 ##1 mc_phase == 2'h2 ##1 mc_phase == 2'h3 ##1 mc_phase == 2'h0;
  endsequence
  property p_mc; mc_phase == 2'h0 |=> s_mc; endproperty
  property p_fph; code_fetch |-> mc_phase == 2'h0; endproperty
  property p_step; code_fetch |-> ##4 code_addr == $past(code_addr, 4) + 16'h0001; endproperty
  property p_hold; mc_phase == 2'h0 && !code_fetch |-> ##4 code_addr == $past(code_addr, 4); endproperty
  property p_dph; instr_done |-> mc_phase == 2'h0; endproperty
  // Branch: two fetches, then one silent cycle
  property p_jmp; instr_done && opcode[4:0] == 5'h01 |->
    !$past(code_fetch, 4) && $past(code_fetch, 8) && $past(code_fetch, 12); endproperty
  property p_call; instr_done && opcode[4:0] == 5'h11 |->
    !$past(code_fetch, 4) && $past(code_fetch, 8) && $past(code_fetch, 12); endproperty
  property p_nop; instr_done && opcode == 8'h00 |-> $past(code_fetch, 4) && $past(mc_phase, 4) == 2'h0; endproperty
  property p_clr; instr_done && opcode == 8'hC3 |-> !psw[7]; endproperty
  property p_set; instr_done && opcode == 8'hD3 |-> psw[7]; endproperty
  property p_par; psw[0] == ^$past(acc); endproperty
  a_mc: assert property (p_mc) else $error("phase order wrong");
  a_fph: assert property (p_fph) else $error("fetch outside phase 0");
  a_step: assert property (p_step) else $error("address not advanced");
  a_hold: assert property (p_hold) else $error("address moved without fetch");
  a_dph: assert property (p_dph) else $error("done outside phase 0");
  a_jmp: assert property (p_jmp) else $error("jump timing wrong");
  a_call: assert property (p_call) else $error("call timing wrong");
  a_nop: assert property (p_nop) else $error("no-op timing wrong");
  a_clr: assert property (p_clr) else $error("carry not cleared");
  a_set: assert property (p_set) else $error("carry not set");
  a_par: assert property (p_par) else $error("parity wrong");
endmodule
bind cit_sequencer cit_seq_props u_props (.clk(clk), .reset(reset), .code_data(code_data), .b_reg(b_reg),
  .bit_in(bit_in), .code_addr(code_addr), .code_fetch(code_fetch), .mc_phase(mc_phase),
  .instr_done(instr_done), .opcode(opcode), .acc(acc), .psw(psw), .mc_count(mc_count));

// ==== testbench/tb_top.sv ====
/*
  Self-checking bench: program bytes with a reference model of
  timing and flags. Assumes the sequencer as top of the design.
*/
`timescale 1ns/1ps
module tb_top;
  logic clk = 0, reset = 1, bit_in = 0, code_fetch, instr_done;
  logic [7:0] b_reg = 8'h00, code_data, opcode, acc, psw;
  logic [15:0] code_addr;
  logic [1:0] mc_phase;
  logic [2:0] mc_count;
  bit [31:0] seed = 56524;
  bit [7:0] ops [8] = '{8'h24, 8'h34, 8'h25, 8'h35, 8'hC3, 8'hD3, 8'hB3, 8'h00};
  int error_cnt = 0, checks_done = 0, nb = 0, gap = 0, a = 0, c = 0, ac = 0, ov = 0;
  int ea, ep, ck, pend = 0, first = 1, last_opnd = 0;
  int q_n[$], q_b[$], q_a[$], q_p[$], q_c[$];
  always #2.5 clk = ~clk;
  cit_sequencer u_dut (.clk(clk), .reset(reset), .code_data(code_data), .b_reg(b_reg), .bit_in(bit_in),
    .code_addr(code_addr), .code_fetch(code_fetch), .mc_phase(mc_phase), .instr_done(instr_done),
    .opcode(opcode), .acc(acc), .psw(psw), .mc_count(mc_count));
  cit_prog_mem u_mem (.code_addr(code_addr), .code_data(code_data));
  function automatic bit [7:0] rnd8();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  task chk(input string nm, input logic [15:0] seen, input int exp);
    checks_done++;
    if (seen !== exp[15:0]) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  // Store one instruction and its expected timing and flags
  task put(input bit [7:0] op, input int d);
    int len, h, s, v;
    len = (op[3:0] == 4'h1 || op[3:1] == 3'h2) ? 2 : 1;
    // One-byte adds use the last operand byte fetched
    v = (len == 2) ? d % 256 : last_opnd;
    if (len == 2) last_opnd = v;
    if ((op[7:4] == 4'h2 || op[7:4] == 4'h3) && op[3:0] >= 4'h4) begin
      h = op[4] ? c : 0;
      s = a + v + h;
      ac = (a % 16 + v % 16 + h) > 15;
      ov = (s > 255) ^ ((a % 128 + v % 128 + h) > 127);
      c = s > 255;
      a = s % 256;
    end
    else if (op == 8'hC3) c = 0;
    else if (op == 8'hD3) c = 1;
    else if (op == 8'hB3) c = !c;
    u_mem.mem[nb] = op;
    if (len == 2) u_mem.mem[nb + 1] = d[7:0];
    nb += len;
    q_n.push_back(len + (op[3:0] == 4'h1));
    q_b.push_back(nb);
    q_a.push_back(a);
    q_p.push_back(c * 128 + ac * 64 + ov * 4 + (^a[7:0]));
    q_c.push_back(1);
  endtask
  task finish_test;
    if (error_cnt == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Random side inputs; unused by the tested opcodes
  always @(negedge clk) begin
    b_reg <= rnd8();
    bit_in <= rnd8() > 8'h7F;
  end
  // Compare at every retirement; flags one clock later for parity lag
  always @(negedge clk) begin
    if (pend && ck) begin
      chk("acc", acc, ea);
      chk("psw", psw, ep);
    end
    pend = 0;
    gap = reset ? 0 : gap + 1;
    if (!reset && instr_done === 1'b1 && q_n.size() > 0) begin
      if (!first) chk("cycles", gap, 4 * q_n[0]);
      chk("mc_count", mc_count, q_n[0]);
      chk("addr", code_addr, q_b[0]);
      ea = q_a.pop_front();
      ep = q_p.pop_front();
      ck = q_c.pop_front();
      void'(q_n.pop_front());
      void'(q_b.pop_front());
      pend = 1;
      first = 0;
      gap = 0;
    end
  end
  initial begin
    #20000;
    error_cnt++;
    finish_test;
  end
  initial begin
    put(8'h00, 0);
    for (int i = 0; i < 16; i++) put(8'(i * 16 + 1), rnd8());
    repeat (48) put(ops[rnd8() % 8], rnd8());
    for (int i = 0; i < 20; i++) put(i < 16 ? 8'(8'h28 + i % 8 + i / 8 * 16) : 8'(8'h26 + i % 2 + (i - 16) / 2 * 16), 0);
    for (int i = nb; i < 256; i++) u_mem.mem[i] = 8'h00;
    repeat (6) @(negedge clk);
    reset = 0;
    while (q_n.size() > 0) @(negedge clk);
    repeat (8) @(negedge clk);
    finish_test;
  end
endmodule
